//--- rtl/prc_pkg.sv
// Shared constants and types for the loop runtime control ends.
// Function
// - Dynamic two-way reference selector feeds loop.
// - Standby/reset stops oscillator, keeps settings, relocks.
// - Controller holds standby at least 1 ms.
// - Loop reset forces divided outputs low.
// - Bypassed outputs ignore loop reset.
// - Lock asserts after 16 ms acquisition.
// - Reset held 1 ms; dividers resume after.
// - Per-output enable stops clock glitchlessly, low.
// - Absent enable means output always runs.
// - Feedback output has no dynamic enable.
// - Powerdown low forces outputs low, loop reset.
// - Controller holds powerdown at least 1 ms.
// - Three-bit select picks the shifted output.
// - Select and direction stable before trigger fall.
// - Direction zero lags, one leads.
// - VCO step moves selected phase one tick, 90 degrees at default divide.
// - Step acts four oscillator cycles after fall.
// - Step high and low four periods each.
// - Divider shift on load fall; pulse 10 ns.
// - Output from divider or reference in bypass.
// - Sticky lock holds until loop reset.
// - Non-sticky lock drops on invalid clocks.
// - Controller may reset loop on lock loss.
// - Lock is asynchronous; synchronise before use.
`default_nettype none
package prc_pkg;
  localparam int NUM_OUT = 6;
  localparam logic [2:0] SEL_SEC1 = 3'h0;
  localparam logic [2:0] SEL_SEC2 = 3'h1;
  localparam logic [2:0] SEL_SEC3 = 3'h2;
  localparam logic [2:0] SEL_SEC4 = 3'h3;
  localparam logic [2:0] SEL_SEC5 = 3'h4;
  localparam logic [2:0] SEL_MAIN = 3'h5;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DWELL_TIME_MS = 1;
  localparam int DWELL_CYC = (DWELL_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_TIME_MS = 16;
  localparam int LOCK_CYC = (LOCK_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int RSTREC_TIME_NS = 1;
  localparam int RSTREC_CYC = (RSTREC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_TIME_NS = 5;
  localparam int SETUP_CYC = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIVLOAD_PULSE_NS = 10;
  localparam int DIVLOAD_CYC = (DIVLOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VCO_STEP_DELAY = 4;
  localparam int VCO_STEP_MIN = 4;
  localparam int ACT_TIMEOUT_CYC = 64;
  localparam int DIV_HALF_DEF = 2;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ENABLE = 4'h4;
  localparam logic [3:0] REG_SHIFT = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int CTRL_REFSEL = 0;
  localparam int CTRL_STANDBY_REQUEST = 1;
  localparam int CTRL_PWRDN = 2;
  localparam int CTRL_LRST = 3;
  localparam int CTRL_AUTO = 4;
  localparam int SHIFT_DIR = 3;
  localparam int SHIFT_KIND = 4;
  localparam int STAT_LOCK = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_HOLD = 2;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [5:0] ENABLE_RST = 6'h3F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    SH_IDLE = 4'h1,
    SH_SETUP = 4'h2,
    SH_LOW = 4'h4,
    SH_HIGH = 4'h8
  } prc_shift_t;
endpackage
`default_nettype wire

//--- rtl/prc_if.sv
// Connection between the loop end and its fabric controller.
`default_nettype none
interface prc_if;
  logic refSelect;
  logic standbyRequest;
  logic powerdownRequestN;
  logic loopReset;
  logic [5:0] outEnable;
  logic [2:0] shiftOutputSelect;
  logic shiftDirection;
  logic vcoStepTriggerN;
  logic dividerShiftTriggerN;
  logic feedbackClock;
  logic [5:0] outClock;
  logic lock;
  modport loop (
    input refSelect, standbyRequest, powerdownRequestN, loopReset, outEnable,
    input shiftOutputSelect, shiftDirection, vcoStepTriggerN, dividerShiftTriggerN, feedbackClock,
    output outClock, lock
  );
  modport ctrl (
    output refSelect, standbyRequest, powerdownRequestN, loopReset, outEnable,
    output shiftOutputSelect, shiftDirection, vcoStepTriggerN, dividerShiftTriggerN, feedbackClock,
    input outClock, lock
  );
endinterface
`default_nettype wire

//--- rtl/prc_loop.sv
// Digital model of the frequency-synthesis loop end with its runtime controls.
`default_nettype none
module prc_loop import prc_pkg::*; #(
  parameter int LOCK_CYCLES = LOCK_CYC,
  parameter int DIV_HALF = DIV_HALF_DEF,
  parameter logic [5:0] ENABLE_PRESENT = 6'h3F,
  parameter int FB_INDEX = 5
) (
  input wire logic clock, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  prc_if.loop link, // Control and clock link.
  input wire logic refClockA, // Reference candidate zero.
  input wire logic refClockB, // Reference candidate one.
  input wire logic [5:0] bypassMask, // Output fed from reference.
  input wire logic [5:0] bypassDivMask, // Bypassed output still divided.
  input wire logic stickyLock // Lock indication is sticky.
);
  localparam int CW = (DIV_HALF > 1) ? $clog2(DIV_HALF) : 1;
  localparam int SW = CW + 1;
  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam int AW = $clog2(ACT_TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(DIV_HALF - 1);
  localparam logic [LW-1:0] LOCK_DONE = LW'(LOCK_CYCLES);
  localparam logic [AW-1:0] ACT_LIMIT = AW'(ACT_TIMEOUT_CYC);
  localparam logic [1:0] REC_DONE = 2'(RSTREC_CYC);

  // Divider state is {level, count}; one step is one oscillator tick.
  function automatic logic [SW-1:0] nxt(input logic [SW-1:0] s);
    if (s[CW-1:0] == CNT_LAST) begin
      nxt = {~s[CW], {CW{1'b0}}};
    end else begin
      nxt = {s[CW], s[CW-1:0] + CW'(1)};
    end
  endfunction

  function automatic logic [SW-1:0] prv(input logic [SW-1:0] s);
    if (s[CW-1:0] == '0) begin
      prv = {~s[CW], CNT_LAST};
    end else begin
      prv = {s[CW], s[CW-1:0] - CW'(1)};
    end
  endfunction

  logic refCur_q, refPrev_q, fbPrev_q;
  logic [AW-1:0] refIdle_q, fbIdle_q;
  logic [1:0] rec_q;
  logic [LW-1:0] lockCnt_q;
  logic lock_q;
  logic stepPrev_q, loadPrev_q;
  logic [VCO_STEP_DELAY-1:0] stepPipe_q;
  logic [2:0] stepSel_q;
  logic stepDir_q;
  logic [5:0] outClock_q;
  logic refEdge, fbEdge, refValid, fbValid, hold, stopAll, loopRun, clocksOk;
  logic stepFall, loadFall, stepApply;

  assign refEdge = refCur_q & ~refPrev_q;
  assign fbEdge = link.feedbackClock & ~fbPrev_q;
  assign refValid = refIdle_q < ACT_LIMIT;
  assign fbValid = fbIdle_q < ACT_LIMIT;
  assign stopAll = link.standbyRequest | ~link.powerdownRequestN;
  assign hold = link.loopReset | stopAll;
  assign loopRun = ~hold & (rec_q == REC_DONE);
  assign clocksOk = refValid & fbValid;
  assign stepFall = stepPrev_q & ~link.vcoStepTriggerN;
  assign loadFall = loadPrev_q & ~link.dividerShiftTriggerN;
  assign stepApply = stepPipe_q[VCO_STEP_DELAY-1];

  // The selected candidate becomes the loop reference with no further logic.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      refCur_q <= 1'b0;
      refPrev_q <= 1'b0;
      fbPrev_q <= 1'b0;
    end else begin
      refCur_q <= link.refSelect ? refClockB : refClockA;
      refPrev_q <= refCur_q;
      fbPrev_q <= link.feedbackClock;
    end
  end

  // A clock counts as valid while it has risen within the activity window.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      refIdle_q <= ACT_LIMIT;
      fbIdle_q <= ACT_LIMIT;
    end else begin
      refIdle_q <= refEdge ? '0 : (refValid ? refIdle_q + AW'(1) : refIdle_q);
      fbIdle_q <= fbEdge ? '0 : (fbValid ? fbIdle_q + AW'(1) : fbIdle_q);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rec_q <= 2'h0;
    end else if (hold) begin
      rec_q <= 2'h0;
    end else if (rec_q != REC_DONE) begin
      rec_q <= rec_q + 2'h1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lockCnt_q <= '0;
    end else if (!loopRun || !clocksOk) begin
      lockCnt_q <= '0;
    end else if (lockCnt_q != LOCK_DONE) begin
      lockCnt_q <= lockCnt_q + LW'(1);
    end
  end

  // Powerdown holds the loop in reset, so it clears a sticky lock too.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lock_q <= 1'b0;
    end else if (link.loopReset || !link.powerdownRequestN) begin
      lock_q <= 1'b0;
    end else if (stickyLock && lock_q) begin
      lock_q <= 1'b1;
    end else begin
      lock_q <= loopRun && clocksOk && (lockCnt_q == LOCK_DONE);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stepPrev_q <= 1'b1;
      loadPrev_q <= 1'b1;
      stepPipe_q <= '0;
      stepSel_q <= 3'h0;
      stepDir_q <= 1'b0;
    end else begin
      stepPrev_q <= link.vcoStepTriggerN;
      loadPrev_q <= link.dividerShiftTriggerN;
      stepPipe_q <= {stepPipe_q[VCO_STEP_DELAY-2:0], stepFall};
      if (stepFall) begin
        stepSel_q <= link.shiftOutputSelect;
        stepDir_q <= link.shiftDirection;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_OUT; i++) begin : g_out
      logic [SW-1:0] live_q, start_q;
      logic gate_q;
      logic tick, stepHit, loadHit, src, effEn, outD;
      assign tick = bypassMask[i] ? refEdge : loopRun;
      assign stepHit = stepApply && (stepSel_q == 3'(i));
      assign loadHit = loadFall && (link.shiftOutputSelect == 3'(i));
      assign src = (bypassMask[i] && !bypassDivMask[i]) ? refCur_q : live_q[CW];
      assign effEn = (ENABLE_PRESENT[i] && i != FB_INDEX) ? link.outEnable[i] : 1'b1;
      assign outD = src & gate_q & ~stopAll & (bypassMask[i] | loopRun);

      // Phase state of a non-bypassed output reloaded after any stop, so shifts survive standby and reset.
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          start_q <= '0;
        end else if (stepHit) begin
          start_q <= stepDir_q ? nxt(start_q) : prv(start_q);
        end else if (loadHit) begin
          start_q <= {~start_q[CW], start_q[CW-1:0]};
        end
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          live_q <= '0;
        end else if (!bypassMask[i] && !loopRun) begin
          live_q <= start_q;
        end else if (stepHit) begin
          live_q <= stepDir_q ? nxt(nxt(live_q)) : live_q;
        end else if (loadHit) begin
          live_q <= {~live_q[CW], live_q[CW-1:0]};
        end else if (tick) begin
          live_q <= nxt(live_q);
        end
      end

      // The gate moves only while the source is low, so no runt pulse appears.
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          gate_q <= 1'b0;
        end else if (!src) begin
          gate_q <= effEn;
        end
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          outClock_q[i] <= 1'b0;
        end else begin
          outClock_q[i] <= outD;
        end
      end
    end
  endgenerate

  assign link.outClock = outClock_q;
  assign link.lock = lock_q;
endmodule
`default_nettype wire

//--- rtl/prc_controller.sv
// Fabric controller end: AXI4-Lite registers driving the loop controls.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`default_nettype none
module prc_controller import prc_pkg::*; #(
  parameter int DWELL_CYCLES = DWELL_CYC,
  parameter int FB_INDEX = 5
) (
  input wire logic clock, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  prc_if.ctrl link, // Control and clock link.
  input wire logic [3:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [3:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready // Read data ready.
);
  localparam int DW = $clog2(DWELL_CYCLES + 1);
  localparam logic [DW-1:0] DWELL_DONE = DW'(DWELL_CYCLES);

  logic [4:0] ctrl_q;
  logic [5:0] enable_q;
  logic lockMeta_q, lockSync_q, lockPrev_q, lostPulse_q, fb_q;
  logic [2:0] act_q;
  logic [2:0] sel_q;
  logic dir_q, kind_q, stepN_q, loadN_q;
  logic [2:0] shCnt_q;
  prc_shift_t state_q;
  logic [2:0] req;
  logic wrGo, rdGo, wrShift;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == REG_CTRL) || (a == REG_ENABLE) || (a == REG_SHIFT) || (a == REG_STATUS);
  endfunction

  assign wrGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rdGo = s_axi_arvalid && s_axi_arready;
  assign wrShift = wrGo && s_axi_wstrb[0] && (s_axi_awaddr == REG_SHIFT);
  assign req[0] = ctrl_q[CTRL_STANDBY_REQUEST];
  assign req[1] = ctrl_q[CTRL_PWRDN];
  assign req[2] = ctrl_q[CTRL_LRST] | lostPulse_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrGo) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RST;
      enable_q <= ENABLE_RST;
    end else if (wrGo && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == REG_CTRL) begin
        ctrl_q <= s_axi_wdata[4:0];
      end
      if (s_axi_awaddr == REG_ENABLE) begin
        enable_q <= s_axi_wdata[5:0];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rdGo) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {27'h0, ctrl_q};
        REG_ENABLE: s_axi_rdata <= {26'h0, enable_q};
        REG_SHIFT: s_axi_rdata <= {27'h0, kind_q, dir_q, sel_q};
        REG_STATUS: s_axi_rdata <= {29'h0, |act_q, state_q != SH_IDLE, lockSync_q};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Two-stage synchroniser; the lock level runs on no fabric clock.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lockMeta_q <= 1'b0;
      lockSync_q <= 1'b0;
      lockPrev_q <= 1'b0;
      lostPulse_q <= 1'b0;
      fb_q <= 1'b0;
    end else begin
      lockMeta_q <= link.lock;
      lockSync_q <= lockMeta_q;
      lockPrev_q <= lockSync_q;
      lostPulse_q <= ctrl_q[CTRL_AUTO] && lockPrev_q && !lockSync_q;
      fb_q <= link.outClock[FB_INDEX];
    end
  end

  // Standby, powerdown and loop reset each stay asserted for the full dwell.
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_dwell
      logic [DW-1:0] cnt_q;
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          act_q[k] <= 1'b0;
          cnt_q <= '0;
        end else if (req[k] && !act_q[k]) begin
          act_q[k] <= 1'b1;
          cnt_q <= '0;
        end else if (act_q[k]) begin
          if (cnt_q != DWELL_DONE) begin
            cnt_q <= cnt_q + DW'(1);
          end else if (!req[k]) begin
            act_q[k] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= SH_IDLE;
      shCnt_q <= 3'h0;
      sel_q <= SEL_SEC1;
      dir_q <= 1'b0;
      kind_q <= 1'b0;
      stepN_q <= 1'b1;
      loadN_q <= 1'b1;
    end else begin
      unique case (state_q)
        SH_IDLE: if (wrShift) begin
          sel_q <= s_axi_wdata[2:0];
          dir_q <= s_axi_wdata[SHIFT_DIR];
          kind_q <= s_axi_wdata[SHIFT_KIND];
          shCnt_q <= 3'(SETUP_CYC - 1);
          state_q <= SH_SETUP;
        end
        SH_SETUP: if (shCnt_q == 3'h0) begin
          stepN_q <= kind_q;
          loadN_q <= ~kind_q;
          shCnt_q <= kind_q ? 3'(DIVLOAD_CYC - 1) : 3'(VCO_STEP_MIN - 1);
          state_q <= SH_LOW;
        end else begin
          shCnt_q <= shCnt_q - 3'h1;
        end
        SH_LOW: if (shCnt_q == 3'h0) begin
          stepN_q <= 1'b1;
          loadN_q <= 1'b1;
          shCnt_q <= 3'(VCO_STEP_MIN - 1);
          state_q <= SH_HIGH;
        end else begin
          shCnt_q <= shCnt_q - 3'h1;
        end
        SH_HIGH: if (shCnt_q == 3'h0) begin
          state_q <= SH_IDLE;
        end else begin
          shCnt_q <= shCnt_q - 3'h1;
        end
        default: state_q <= SH_IDLE;
      endcase
    end
  end

  assign link.refSelect = ctrl_q[CTRL_REFSEL];
  assign link.standbyRequest = act_q[0];
  assign link.powerdownRequestN = ~act_q[1];
  assign link.loopReset = act_q[2];
  assign link.outEnable = enable_q;
  assign link.shiftOutputSelect = sel_q;
  assign link.shiftDirection = dir_q;
  assign link.vcoStepTriggerN = stepN_q;
  assign link.dividerShiftTriggerN = loadN_q;
  assign link.feedbackClock = fb_q;
endmodule
`default_nettype wire

//--- dv/prc_monitor.sv
// Concurrent checks on the link between the loop end and its controller.
`default_nettype none
module prc_monitor import prc_pkg::*; #(
  parameter int DWELL_CYCLES = DWELL_CYC,
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  input wire logic clock, // Clock.
  input wire logic reset, // Reset.
  input wire logic standbyRequest, // Standby.
  input wire logic powerdownRequestN, // Powerdown.
  input wire logic loopReset, // Loop reset.
  input wire logic [5:0] outEnable, // Enables.
  input wire logic [2:0] shiftOutputSelect, // Target.
  input wire logic shiftDirection, // Sense.
  input wire logic vcoStepTriggerN, // Step.
  input wire logic dividerShiftTriggerN, // Load.
  input wire logic [5:0] outClock, // Outputs.
  input wire logic lock, // Lock.
  input wire logic [5:0] bypassMask // Bypass.
);
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic [2:0] holdReq;
  int holdCnt_q [3];
  int runCnt_q;
  assign holdReq = {loopReset, ~powerdownRequestN, standbyRequest};
  // Cycles each request has been held, and cycles of free running.
  always_ff @(posedge clock) begin
    for (int k = 0; k < 3; k++) begin
      holdCnt_q[k] <= (reset || !holdReq[k]) ? 0 : holdCnt_q[k] + 1;
    end
  end
  always_ff @(posedge clock) begin
    runCnt_q <= (reset || holdReq != 3'h0) ? 0 : runCnt_q + 1;
  end
  a_reset_out_low: assert property (loopReset [*2] |-> (outClock & ~bypassMask) == 6'h00)
    else $error("outputs run in loop reset");
  a_pwrdn_out_low: assert property (!powerdownRequestN [*2] |-> outClock == 6'h00)
    else $error("outputs run in powerdown");
  a_standby_out_low: assert property (standbyRequest [*3] |-> outClock == 6'h00)
    else $error("outputs run in standby");
  for (genvar j = 0; j < 5; j++) begin : g_en
    a_enable_out_low: assert property (!outEnable[j] [*8] |-> !outClock[j])
      else $error("disabled output runs");
  end
  a_standby_dwell_min: assert property ($fell(standbyRequest) |-> holdCnt_q[0] >= DWELL_CYCLES + 1)
    else $error("standby too short");
  a_pwrdn_dwell_min: assert property ($rose(powerdownRequestN) |-> holdCnt_q[1] >= DWELL_CYCLES + 1)
    else $error("powerdown too short");
  a_reset_dwell_min: assert property ($fell(loopReset) |-> holdCnt_q[2] >= DWELL_CYCLES + 1)
    else $error("loop reset too short");
  a_lock_time_min: assert property ($rose(lock) |-> runCnt_q >= LOCK_CYCLES)
    else $error("lock too early");
  a_sticky_lock_clear: assert property (loopReset [*2] |-> !lock)
    else $error("lock held in reset");
  a_step_low_width: assert property ($fell(vcoStepTriggerN) |-> !vcoStepTriggerN [*4])
    else $error("step pulse short");
  a_shift_setup_held: assert property ($fell(vcoStepTriggerN) || $fell(dividerShiftTriggerN)
    |-> $stable(shiftOutputSelect) && $stable(shiftDirection))
    else $error("select moved at trigger");
  c_step: cover property ($fell(vcoStepTriggerN));
  c_load: cover property ($fell(dividerShiftTriggerN));
  c_lock: cover property ($rose(lock));
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Bench joining the loop end and its controller, driven over AXI4-Lite.
`default_nettype none
module tb_top;
  import prc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LK = 50;
  localparam int DW = 20;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic refClockA = 1'b0, refClockB = 1'b0, refRunA = 1'b1, refRunB = 1'b1, stickyLock = 1'b0;
  logic [2:0] refCnt = 3'h0;
  logic [5:0] bypassMask = 6'h00, msk, seen;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [1:0] bq [$];
  logic [63:0] rq [$];
  logic [63:0] rnote;
  logic [2:0] sel;
  logic dir, kind;
  int err_count = 0, tests_run = 0, n, d0, d1;
  prc_if link();
  prc_loop #(.LOCK_CYCLES(LK), .ENABLE_PRESENT(6'h1F)) prc_loop_inst (.clock(clock), .reset(reset),
    .link(link), .refClockA(refClockA), .refClockB(refClockB), .bypassMask(bypassMask),
    .bypassDivMask(6'h00), .stickyLock(stickyLock));
  prc_controller #(.DWELL_CYCLES(DW)) prc_controller_inst (.clock(clock), .reset(reset), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1));
  prc_monitor #(.DWELL_CYCLES(DW), .LOCK_CYCLES(LK)) prc_monitor_inst (.clock(clock), .reset(reset),
    .standbyRequest(link.standbyRequest), .powerdownRequestN(link.powerdownRequestN),
    .loopReset(link.loopReset), .outEnable(link.outEnable), .shiftOutputSelect(link.shiftOutputSelect),
    .shiftDirection(link.shiftDirection), .vcoStepTriggerN(link.vcoStepTriggerN),
    .dividerShiftTriggerN(link.dividerShiftTriggerN), .outClock(link.outClock), .lock(link.lock),
    .bypassMask(bypassMask));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    refCnt <= (refCnt == 3'h5) ? 3'h0 : refCnt + 3'h1;
    refClockA <= refRunA && refCnt < 3'h3;
    refClockB <= refRunB && refCnt < 3'h3;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    int k;
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bound(k, 50);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    int k;
    rq.push_back({m, e});
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    bound(k, 50);
  endtask
  // Cycles from a rise of output 0 (output 1 when s is 0) to the next rise of output s.
  task automatic phase(input int s, output int d);
    int r, k;
    logic p;
    r = (s == 0) ? 1 : 0;
    for (k = 0; k < 20 && link.outClock[r] !== 1'b0; k++) @(posedge clock);
    for (k = k; k < 20 && link.outClock[r] !== 1'b1; k++) @(posedge clock);
    bound(k, 20);
    p = link.outClock[s];
    for (d = 0; d < 20; d++) begin
      @(posedge clock);
      if (link.outClock[s] === 1'b1 && p === 1'b0) break;
      p = link.outClock[s];
    end
  endtask
  always @(posedge clock) begin
    if (bvalid === 1'b1) check("bresp", 32'(bresp), 32'(bq.pop_front()));
    if (rvalid === 1'b1) begin
      rnote = rq.pop_front();
      check("rdata", rdata & rnote[63:32], rnote[31:0]);
    end
  end
  task automatic await_lock(input logic v);
    for (n = 0; n < 600 && link.lock !== v; n++) @(posedge clock);
    bound(n, 600);
  endtask
  initial begin
    n = $urandom(32'hB865);
    repeat (2) @(posedge clock);
    check("idle", {link.refSelect, link.standbyRequest, link.powerdownRequestN, link.loopReset,
      link.vcoStepTriggerN, link.dividerShiftTriggerN, link.outClock, link.lock}, 32'h580);
    @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    axi_rd(REG_CTRL, 32'h0, 32'h1F);
    axi_rd(REG_ENABLE, 32'h3F, 32'h3F);
    axi_wr(REG_CTRL, 32'h1F, 4'h0, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h0, 32'h1F);
    axi_wr(4'h6, $urandom, 4'hF, RESP_SLVERR);
    await_lock(1'b1);
    axi_rd(REG_STATUS, 32'h1, 32'h1);
    msk = 6'($urandom);
    axi_wr(REG_ENABLE, 32'(msk), 4'hF, RESP_OKAY);
    repeat (10) @(posedge clock);
    seen = 6'h00;
    repeat (8) begin
      @(posedge clock);
      seen |= link.outClock;
    end
    check("enable", 32'(seen), 32'(msk | 6'h20));
    axi_wr(REG_ENABLE, 32'h3F, 4'hF, RESP_OKAY);
    for (int k = 0; k < 24; k++) begin
      sel = 3'(k % 6);
      dir = 1'(k / 6);
      kind = 1'(k / 12);
      phase(sel, d0);
      axi_wr(REG_SHIFT, {27'h0, kind, dir, sel}, 4'hF, RESP_OKAY);
      check("select", 32'(link.shiftOutputSelect), 32'(sel));
      for (n = 0; n < 40 && (link.vcoStepTriggerN & link.dividerShiftTriggerN) === 1'b1; n++) @(posedge clock);
      bound(n, 40);
      check("trigger", 32'(link.vcoStepTriggerN), 32'(kind));
      axi_rd(REG_SHIFT, {27'h0, kind, dir, sel}, 32'h1F);
      repeat (12) @(posedge clock);
      phase(sel, d1);
      if (sel != 3'h5) check("phase", 32'((d1 - d0 + 8) % 4), (kind || dir) ? 32'h3 : 32'h1);
    end
    axi_wr(REG_CTRL, 32'h11, 4'hF, RESP_OKAY);
    check("refsel", 32'(link.refSelect), 32'h1);
    refRunA <= 1'b0;
    repeat (200) @(posedge clock);
    check("lock", 32'(link.lock), 32'h1);
    refRunB <= 1'b0;
    await_lock(1'b0);
    for (n = 0; n < 300 && link.loopReset !== 1'b1; n++) @(posedge clock);
    bound(n, 300);
    refRunA <= 1'b1;
    refRunB <= 1'b1;
    axi_wr(REG_CTRL, 32'h0, 4'hF, RESP_OKAY);
    await_lock(1'b1);
    stickyLock <= 1'b1;
    refRunA <= 1'b0;
    repeat (200) @(posedge clock);
    check("sticky", 32'(link.lock), 32'h1);
    refRunA <= 1'b1;
    bypassMask <= 6'h01;
    for (int b = 1; b < 4; b++) begin
      axi_wr(REG_CTRL, 32'h1 << b, 4'hF, RESP_OKAY);
      axi_wr(REG_CTRL, 32'h0, 4'hF, RESP_OKAY);
      seen = 6'h00;
      repeat (10) begin
        @(posedge clock);
        seen |= link.outClock;
      end
      check("held", 32'(seen), (b == 3) ? 32'h1 : 32'h0);
      repeat (LK + 150) @(posedge clock);
      check("relock", 32'(link.lock), 32'h1);
    end
    finish_test();
  end
endmodule
`default_nettype wire
